/* File: src/acs_pkg.sv */
// Shared constants and types of the conversion sequencer.
package acs_pkg;
  // Clock and timing figures in their own units.
  localparam int CLK_PERIOD_NS = 8;
  localparam int CONV_ANALOG_NS = 9000;
  localparam int CONV_TEMP_NS = 27000;
  localparam int ACQ_NS = 400;
  localparam int SETTLE_NS = 100;
  // Widths.
  localparam int RESULT_W = 10;
  localparam int CHAN_W = 3;
  localparam int TIMER_W = 12;
  // Cycle counts derived from the figures above.
  localparam int CONV_ANALOG_CYC = CONV_ANALOG_NS / CLK_PERIOD_NS;
  localparam int CONV_TEMP_CYC = CONV_TEMP_NS / CLK_PERIOD_NS;
  localparam int ACQ_CYC = (ACQ_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int SETTLE_CYC =
    (SETTLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int STEP_ANALOG_CYC = CONV_ANALOG_CYC / (RESULT_W + 1);
  localparam int STEP_TEMP_CYC = CONV_TEMP_CYC / (RESULT_W + 1);
  // Channel selection and control byte decode.
  localparam logic [2:0] CHAN_TEMP = 3'h0;
  localparam logic [2:0] CHAN_RESET = CHAN_TEMP;
  localparam logic [7:0] CTRL_ADDR_MASK = 8'hf8;
  // Temperature scaling.
  localparam int TEMP_OFFSET_C = 103;
  localparam int CODES_PER_DEG = 4;
  localparam logic [10:0] TEMP_OFFSET_Q =
    11'(TEMP_OFFSET_C * CODES_PER_DEG);
  // Sequencer states.
  typedef enum logic [2:0]
  {
    ST_ACQ = 3'b001,
    ST_CONV = 3'b010,
    ST_DOWN = 3'b100
  } acs_state_type;
endpackage

/* File: src/acs_sar_if.sv */
// Link between the sequencer and its successive-approximation engine.
`timescale 1ns/1ps
`default_nettype none
interface acs_sar_if #(parameter int W = 10);
  logic start;
  logic step;
  logic cmp_above;
  logic [W-1:0] code;
  logic done;
  modport engine (input start, input step, input cmp_above,
                  output code, output done);
  modport seq (output start, output step, output cmp_above,
               input code, input done);
endinterface
`default_nettype wire

/* File: src/acs_sar_engine.sv */
// Successive-approximation register that settles one bit per step.
`timescale 1ns/1ps
`default_nettype none
module acs_sar_engine #(parameter int W = 10)
(
  // Clock and reset.
  input wire logic i_clk_sys,
  input wire logic i_resetn,
  // Sequencer side.
  acs_sar_if.engine sar
);
  localparam int IDX_W = $clog2(W);
  localparam logic [W-1:0] MSB_TRIAL = {1'b1, {(W-1){1'b0}}};
  logic [IDX_W-1:0] bit_idx;
  logic active;

  // A bit is kept when the input is at or above the trial level, which
  // yields straight binary with transitions at whole LSB steps.
  always_ff @(posedge i_clk_sys or negedge i_resetn)
  begin
    if (!i_resetn)
    begin
      sar.code <= '0;
      bit_idx <= '0;
      active <= 1'b0;
      sar.done <= 1'b0;
    end
    else if (sar.start)
    begin
      sar.code <= MSB_TRIAL; // [RULE10]
      bit_idx <= IDX_W'(W - 1);
      active <= 1'b1;
      sar.done <= 1'b0;
    end
    else if (sar.step && active)
    begin
      if (!sar.cmp_above)
        sar.code[bit_idx] <= 1'b0; // [RULE10]
      if (bit_idx != '0)
      begin
        sar.code[IDX_W'(bit_idx - 1'b1)] <= 1'b1;
        bit_idx <= IDX_W'(bit_idx - 1'b1);
      end
      else
      begin
        active <= 1'b0;
        sar.done <= 1'b1;
      end
    end
  end

  default clocking cb @(posedge i_clk_sys);
  endclocking
  default disable iff (!i_resetn);

  msb_trial_a: assert property ( // [RULE10]
    sar.start |=> sar.code == MSB_TRIAL)
    else $error("First trial is not the midscale code.");
  last_bit_a: assert property ( // [RULE10]
    active && sar.step && !sar.start && bit_idx == '0
    |=> sar.done && !active)
    else $error("Engine did not finish after the last bit.");
endmodule
`default_nettype wire

/* File: src/acs_sequencer.sv */
// Conversion sequencer: start, busy timing, acquisition and result coding.
// Contract
// [RULE1] Start falling edge: hold sampler, begin conversion.
// [RULE2] Busy high 9 us analog, 27 us temperature.
// [RULE3] Conversions paced by internal clock only.
// [RULE4] Temperature is channel zero, takes 27 us.
// [RULE5] Channel code 000 selects temperature sensor.
// [RULE6] Channel selection resets to temperature sensor.
// [RULE7] Host waits 400 ns acquisition before start.
// [RULE8] Acquisition from conversion end to start edge.
// [RULE9] Host keeps 100 ns settling after conversion.
// [RULE10] Straight binary ten-bit result, LSB steps.
// [RULE11] Temperature equals code over four minus 103.
// [RULE12] Codes match listed temperature table points.
// [RULE13] Host reads result after busy falls.
// [RULE14] Address loads only when upper five bits zero.
// [RULE15] Start low at end: power down until rise.
// [RULE16] Result latched at busy fall, held until replaced.
`timescale 1ns/1ps
`default_nettype none
module acs_sequencer
(
  // Clock and reset.
  input wire logic i_clk_sys,
  input wire logic i_resetn,
  // Conversion start strobe from the host.
  input wire logic i_convert_start_n,
  // Control byte written through the serial port.
  input wire logic i_ctrl_wr,
  input wire logic [7:0] i_ctrl_byte,
  // Comparator decision from the analog core.
  input wire logic i_cmp_above,
  // Conversion status.
  output logic o_busy,
  output logic o_hold,
  output logic o_acquiring,
  output logic o_settled,
  output logic o_acq_done,
  output logic o_power_down,
  // Channel and trial code to the analog core.
  output logic [acs_pkg::CHAN_W-1:0] o_channel,
  output logic o_temp_selected,
  output logic [acs_pkg::RESULT_W-1:0] o_dac_code,
  // Result.
  output logic [acs_pkg::RESULT_W-1:0] o_result,
  output logic o_result_new,
  output logic o_temp_valid,
  output logic signed [acs_pkg::RESULT_W:0] o_temp_qdeg
);
  localparam int TW = acs_pkg::TIMER_W;

  acs_sar_if #(.W(acs_pkg::RESULT_W)) sar();

  acs_pkg::acs_state_type state;
  logic start_prev;
  logic start_fall;
  logic start_rise;
  logic conv_temp;
  logic conv_end;
  logic [TW-1:0] timer;
  logic [TW-1:0] step_cnt;
  logic [TW-1:0] step_len;
  logic [TW-1:0] acq_cnt;
  logic sar_start;
  logic sar_step;

  // Conversion length for the channel latched at the start.
  function automatic logic [TW-1:0] conv_cycles(input logic is_temp);
    conv_cycles = is_temp ? TW'(acs_pkg::CONV_TEMP_CYC)
                          : TW'(acs_pkg::CONV_ANALOG_CYC);
  endfunction

  // Spacing of bit decisions for the channel latched at the start.
  function automatic logic [TW-1:0] step_cycles(input logic is_temp);
    step_cycles = is_temp ? TW'(acs_pkg::STEP_TEMP_CYC)
                          : TW'(acs_pkg::STEP_ANALOG_CYC);
  endfunction

  // The strobe is taken as synchronous, so edges come from one register.
  assign start_fall = start_prev && !i_convert_start_n;
  assign start_rise = !start_prev && i_convert_start_n;
  assign conv_end = (state == acs_pkg::ST_CONV) && (timer == '0);
  assign step_len = step_cycles(conv_temp);

  assign sar.start = sar_start;
  assign sar.step = sar_step;
  assign sar.cmp_above = i_cmp_above;
  assign o_dac_code = sar.code;

  always_ff @(posedge i_clk_sys or negedge i_resetn)
  begin
    if (!i_resetn)
      start_prev <= 1'b1;
    else
      start_prev <= i_convert_start_n;
  end

  // Channel address register; bytes with any upper bit set belong to
  // another register and leave the channel alone.
  always_ff @(posedge i_clk_sys or negedge i_resetn)
  begin
    if (!i_resetn)
    begin
      o_channel <= acs_pkg::CHAN_RESET; // [RULE6]
      o_temp_selected <= 1'b1;
    end
    else if (i_ctrl_wr && (i_ctrl_byte & acs_pkg::CTRL_ADDR_MASK) == '0)
    begin
      o_channel <= i_ctrl_byte[acs_pkg::CHAN_W-1:0]; // [RULE14]
      o_temp_selected <=
        i_ctrl_byte[acs_pkg::CHAN_W-1:0] == acs_pkg::CHAN_TEMP; // [RULE5]
    end
  end

  // Main sequence. A start edge is only honoured from acquisition; edges
  // during a conversion are ignored rather than restarting it.
  always_ff @(posedge i_clk_sys or negedge i_resetn)
  begin
    if (!i_resetn)
    begin
      state <= acs_pkg::ST_ACQ;
      o_busy <= 1'b0;
      o_hold <= 1'b0;
      o_power_down <= 1'b0;
      conv_temp <= 1'b0;
      timer <= '0;
    end
    else
    begin
      case (state)
        acs_pkg::ST_ACQ:
        begin
          if (start_fall)
          begin
            state <= acs_pkg::ST_CONV;
            o_hold <= 1'b1; // [RULE1]
            o_busy <= 1'b1; // [RULE2]
            conv_temp <= o_temp_selected; // [RULE4]
            timer <= TW'(conv_cycles(o_temp_selected) - 1'b1); // [RULE2]
          end
        end
        acs_pkg::ST_CONV:
        begin
          if (timer == '0)
          begin
            o_busy <= 1'b0; // [RULE2]
            o_hold <= 1'b0;
            if (!i_convert_start_n)
            begin
              state <= acs_pkg::ST_DOWN;
              o_power_down <= 1'b1; // [RULE15]
            end
            else
              state <= acs_pkg::ST_ACQ;
          end
          else
            timer <= TW'(timer - 1'b1);
        end
        acs_pkg::ST_DOWN:
        begin
          if (start_rise)
          begin
            state <= acs_pkg::ST_ACQ;
            o_power_down <= 1'b0; // [RULE15]
          end
        end
        default:
        begin
          state <= acs_pkg::ST_ACQ;
          o_busy <= 1'b0;
          o_hold <= 1'b0;
          o_power_down <= 1'b0;
        end
      endcase
    end
  end

  // Internal conversion clock: a divider that paces the bit decisions,
  // so no host clock is involved while converting.
  always_ff @(posedge i_clk_sys or negedge i_resetn)
  begin
    if (!i_resetn)
    begin
      sar_start <= 1'b0;
      sar_step <= 1'b0;
      step_cnt <= '0;
    end
    else
    begin
      sar_start <= (state == acs_pkg::ST_ACQ) && start_fall; // [RULE1]
      sar_step <= 1'b0;
      if (state == acs_pkg::ST_ACQ)
        step_cnt <= step_cycles(o_temp_selected);
      else if (state == acs_pkg::ST_CONV)
      begin
        if (step_cnt == TW'(1))
        begin
          sar_step <= 1'b1; // [RULE3]
          step_cnt <= step_len;
        end
        else
          step_cnt <= TW'(step_cnt - 1'b1);
      end
    end
  end

  // Acquisition phase and its elapsed-time flags. The host owns the wait,
  // the flags only report whether it has passed.
  always_ff @(posedge i_clk_sys or negedge i_resetn)
  begin
    if (!i_resetn)
    begin
      o_acquiring <= 1'b1;
      o_settled <= 1'b0;
      o_acq_done <= 1'b0;
      acq_cnt <= '0;
    end
    else if (conv_end)
    begin
      o_acquiring <= 1'b1; // [RULE8]
      o_settled <= 1'b0;
      o_acq_done <= 1'b0;
      acq_cnt <= '0;
    end
    else if (state == acs_pkg::ST_ACQ && start_fall)
    begin
      o_acquiring <= 1'b0; // [RULE8]
      o_settled <= 1'b0;
      o_acq_done <= 1'b0;
    end
    else if (o_acquiring && !o_acq_done)
    begin
      acq_cnt <= TW'(acq_cnt + 1'b1);
      if (acq_cnt == TW'(acs_pkg::SETTLE_CYC - 1))
        o_settled <= 1'b1; // [RULE9]
      if (acq_cnt == TW'(acs_pkg::ACQ_CYC - 1))
        o_acq_done <= 1'b1; // [RULE7]
    end
  end

  // Result register: replaced only at the end of a conversion.
  always_ff @(posedge i_clk_sys or negedge i_resetn)
  begin
    if (!i_resetn)
    begin
      o_result <= '0;
      o_result_new <= 1'b0;
      o_temp_valid <= 1'b0;
      o_temp_qdeg <= '0;
    end
    else
    begin
      o_result_new <= conv_end;
      if (conv_end)
      begin
        o_result <= sar.code; // [RULE16]
        o_temp_valid <= conv_temp;
        o_temp_qdeg <= $signed({1'b0, sar.code} -
                               acs_pkg::TEMP_OFFSET_Q); // [RULE11] [RULE12]
      end
    end
  end

  acs_sar_engine #(.W(acs_pkg::RESULT_W)) u_engine
  (
    .i_clk_sys(i_clk_sys),
    .i_resetn(i_resetn),
    .sar(sar.engine)
  );

  // Helper for the checks below: length of the current busy interval.
  logic [TW-1:0] busy_len;
  always_ff @(posedge i_clk_sys or negedge i_resetn)
  begin
    if (!i_resetn)
      busy_len <= '0;
    else if (o_busy)
      busy_len <= TW'(busy_len + 1'b1);
    else
      busy_len <= '0;
  end

  default clocking cb @(posedge i_clk_sys);
  endclocking
  default disable iff (!i_resetn);

  sequence start_taken;
    state == acs_pkg::ST_ACQ && start_fall;
  endsequence

  sequence end_held_low;
    conv_end && !i_convert_start_n;
  endsequence

  start_hold_a: assert property (start_taken |=> o_hold && o_busy) // [RULE1]
    else $error("Start edge did not enter hold with busy.");
  analog_busy_a: assert property ( // [RULE2]
    $fell(o_busy) && !conv_temp
    |-> busy_len == TW'(acs_pkg::CONV_ANALOG_CYC))
    else $error("Analog conversion busy length is wrong.");
  temp_busy_a: assert property ( // [RULE4]
    $fell(o_busy) && conv_temp
    |-> busy_len == TW'(acs_pkg::CONV_TEMP_CYC))
    else $error("Temperature conversion busy length is wrong.");
  step_inside_a: assert property (sar_step |-> o_busy) // [RULE3]
    else $error("Bit decision paced outside a conversion.");
  sar_done_a: assert property (conv_end |-> sar.done) // [RULE10]
    else $error("Conversion ended before all bits were decided.");
  chan_reset_a: assert property ( // [RULE6]
    $rose(i_resetn) |-> o_channel == acs_pkg::CHAN_RESET)
    else $error("Channel does not reset to the sensor.");
  chan_load_a: assert property ( // [RULE14]
    i_ctrl_wr && i_ctrl_byte[7:3] == '0
    |=> o_channel == $past(i_ctrl_byte[2:0])
        && o_temp_selected == ($past(i_ctrl_byte[2:0]) == '0))
    else $error("Address byte did not load the channel.");
  chan_keep_a: assert property ( // [RULE14]
    i_ctrl_wr && i_ctrl_byte[7:3] != '0 |=> $stable(o_channel))
    else $error("Non-address byte changed the channel.");
  pd_enter_a: assert property ( // [RULE15]
    end_held_low |=> o_power_down && !o_busy)
    else $error("Power down not entered at conversion end.");
  pd_wake_a: assert property ( // [RULE15]
    o_power_down |=> o_power_down == !$past(start_rise))
    else $error("Power down not kept until a start rising edge.");
  acq_phase_a: assert property ( // [RULE8]
    $fell(o_busy) |-> o_acquiring ##0 o_result_new)
    else $error("Acquisition did not start at conversion end.");
  result_hold_a: assert property ( // [RULE16]
    !o_result_new |-> $stable(o_result))
    else $error("Result changed without a conversion end.");
  temp_point_a: assert property ( // [RULE12]
    o_temp_valid && o_result == 10'h200 |-> o_temp_qdeg == 11'sh064)
    else $error("Midscale code is not plus 25 degrees.");
endmodule
`default_nettype wire

/* File: bench/acs_host_model.sv */
// Host and comparator model facing the conversion sequencer.
`timescale 1ns/1ps
`default_nettype none
module acs_host_model
(
  // Clock and reset.
  input wire logic i_clk_sys,
  input wire logic i_resetn,
  // Requests from the bench.
  input wire logic i_go,
  input wire logic i_keep_low,
  input wire logic [9:0] i_level,
  // Status from the sequencer.
  input wire logic i_acq_done,
  input wire logic [9:0] i_dac_code,
  // Drives toward the sequencer.
  output logic o_convert_start_n,
  output logic o_cmp_above
);
  int low_cnt;
  // An ideal comparator, so the final code equals the applied level.
  assign o_cmp_above = (i_level >= i_dac_code);
  // Start only once acquisition has run its full time.
  always @(negedge i_clk_sys or negedge i_resetn)
  begin
    if (!i_resetn)
    begin
      o_convert_start_n <= 1'b1;
      low_cnt <= 0;
    end
    else if (o_convert_start_n && i_go && i_acq_done)
    begin
      o_convert_start_n <= 1'b0;
      low_cnt <= 0;
    end
    else if (!o_convert_start_n)
    begin
      low_cnt <= low_cnt + 1;
      if (low_cnt >= 2 && !i_keep_low)
        o_convert_start_n <= 1'b1;
    end
  end
endmodule
`default_nettype wire

/* File: bench/test_adc_conversion_sequencer.sv */
// Self-checking bench of the conversion sequencer.
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin checks++; if ((a) !== (b)) begin failures++; \
  $display("BAD t=%0t got=%h exp=%h", $time, a, b); end end
module test_adc_conversion_sequencer;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic ctrl_wr = 1'b0;
  logic [7:0] ctrl_byte = 8'h00;
  logic go = 1'b0;
  logic keep_low = 1'b0;
  logic [9:0] level = 10'h000;
  logic start_n, cmp_above, busy, hold, acquiring, settled, acq_done;
  logic power_down, temp_sel, result_new, temp_valid;
  logic [2:0] channel;
  logic [9:0] dac_code, result;
  logic signed [10:0] temp_qdeg;
  int failures = 0;
  int checks = 0;
  initial forever #4 clk = ~clk;
  acs_sequencer dut_u (.i_clk_sys(clk), .i_resetn(rst_n),
    .i_convert_start_n(start_n), .i_ctrl_wr(ctrl_wr),
    .i_ctrl_byte(ctrl_byte), .i_cmp_above(cmp_above), .o_busy(busy),
    .o_hold(hold), .o_acquiring(acquiring), .o_settled(settled),
    .o_acq_done(acq_done), .o_power_down(power_down),
    .o_channel(channel), .o_temp_selected(temp_sel),
    .o_dac_code(dac_code), .o_result(result), .o_result_new(result_new),
    .o_temp_valid(temp_valid), .o_temp_qdeg(temp_qdeg));
  acs_host_model host_u (.i_clk_sys(clk), .i_resetn(rst_n), .i_go(go),
    .i_keep_low(keep_low), .i_level(level), .i_acq_done(acq_done),
    .i_dac_code(dac_code), .o_convert_start_n(start_n),
    .o_cmp_above(cmp_above));
  task automatic final_report();
    if (failures == 0 && checks > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  task automatic wr_ctrl(input logic [7:0] b);
    ctrl_byte = b;
    ctrl_wr = 1'b1;
    @(negedge clk);
    ctrl_wr = 1'b0;
    @(negedge clk);
  endtask
  // One conversion; busy length is counted in whole clock cycles.
  task automatic run_conv(input logic [9:0] lvl, input logic temp);
    int n;
    n = 0;
    level = lvl;
    go = 1'b1;
    while (busy !== 1'b1 && n < 200)
    begin
      @(negedge clk);
      n++;
    end
    go = 1'b0;
    `CHK(hold, 1'b1)
    `CHK(acquiring, 1'b0)
    // The first trial is midscale one cycle into the conversion.
    @(negedge clk);
    `CHK(dac_code, 10'h200)
    n = 1;
    while (busy === 1'b1 && n < 4000)
    begin
      @(negedge clk);
      n++;
    end
    `CHK(n, temp ? 3375 : 1125)
    `CHK(hold, 1'b0)
    `CHK(acquiring, 1'b1)
    `CHK(settled, 1'b0)
    `CHK(acq_done, 1'b0)
    `CHK(result_new, 1'b1)
    `CHK(result, lvl)
    `CHK(dac_code, lvl)
    `CHK(temp_valid, temp)
    @(negedge clk);
    `CHK(result_new, 1'b0)
  endtask
  task automatic test_reset();
    `CHK(channel, 3'h0)
    `CHK(temp_sel, 1'b1)
    `CHK(busy, 1'b0)
    `CHK(power_down, 1'b0)
    `CHK(acquiring, 1'b1)
    `CHK(result, 10'h000)
  endtask
  task automatic test_ctrl();
    for (int c = 7; c >= 0; c--)
    begin
      wr_ctrl(8'(c));
      `CHK(channel, 3'(c))
      `CHK(temp_sel, (c == 0))
    end
    wr_ctrl(8'h09);
    `CHK(channel, 3'h0)
    wr_ctrl(8'h81);
    `CHK(channel, 3'h0)
  endtask
  task automatic test_analog();
    logic [9:0] lv[3] = '{10'h3ff, 10'h000, 10'h155};
    wr_ctrl(8'h01);
    foreach (lv[i])
      run_conv(lv[i], 1'b0);
  endtask
  // Table points in quarter degrees: code minus offset, four per degree.
  task automatic test_temp();
    logic [9:0] code[3] = '{10'h0c0, 10'h200, 10'h390};
    int deg[3] = '{-55, 25, 125};
    wr_ctrl(8'h00);
    foreach (code[i])
    begin
      run_conv(code[i], 1'b1);
      `CHK(temp_qdeg, 11'(deg[i] * 4))
    end
  endtask
  // Start held low across the end of a conversion powers the core down.
  task automatic test_power_down();
    wr_ctrl(8'h01);
    keep_low = 1'b1;
    run_conv(10'h2aa, 1'b0);
    `CHK(power_down, 1'b1)
    repeat (5) @(negedge clk);
    `CHK(power_down, 1'b1)
    keep_low = 1'b0;
    repeat (3) @(negedge clk);
    `CHK(power_down, 1'b0)
    repeat (60) @(negedge clk);
    `CHK(settled, 1'b1)
    `CHK(acq_done, 1'b1)
  endtask
  // A reset in mid conversion abandons it and restores the idle state.
  task automatic test_mid_reset();
    wr_ctrl(8'h02);
    level = 10'h123;
    go = 1'b1;
    repeat (100) @(negedge clk);
    go = 1'b0;
    `CHK(busy, 1'b1)
    rst_n = 1'b0;
    repeat (2) @(negedge clk);
    rst_n = 1'b1;
    @(negedge clk);
    test_reset();
  endtask
  initial
  begin
    repeat (8) @(negedge clk);
    rst_n = 1'b1;
    @(negedge clk);
    test_reset();
    test_ctrl();
    test_analog();
    test_temp();
    test_power_down();
    test_mid_reset();
    final_report();
  end
  // Cut a hang short well beyond the expected run of about 15000 cycles.
  initial
  begin
    #(60000 * 8);
    failures++;
    final_report();
  end
endmodule
`default_nettype wire
